// *** tb/afr_host_model.sv ***
// Host controller model issuing one-cycle register reads and writes.
// Assumes requests are sampled on the rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module afr_host_model (
	// Clock
	input  wire logic          clk_i,
	// Request side
	output logic               host_wr_o,
	output logic               host_rd_o,
	output afr_pkg::afr_addr_t host_addr_o,
	output afr_pkg::afr_word_t host_wdata_o
);
	import afr_pkg::*;
	initial begin
		host_wr_o    = 1'b0;
		host_rd_o    = 1'b0;
		host_addr_o  = '0;
		host_wdata_o = '0;
	end
	task automatic wr(input afr_addr_t a, input afr_word_t d);
		@(posedge clk_i);
		host_wr_o    <= 1'b1;
		host_rd_o    <= 1'b0;
		host_addr_o  <= a;
		host_wdata_o <= d;
	endtask : wr
	// Unused data lines are inverted so a stale value is never mistaken for a fresh one.
	task automatic rd(input afr_addr_t a);
		@(posedge clk_i);
		host_wr_o    <= 1'b0;
		host_rd_o    <= 1'b1;
		host_addr_o  <= a;
		host_wdata_o <= ~host_wdata_o;
	endtask : rd
	task automatic idle();
		@(posedge clk_i);
		host_wr_o    <= 1'b0;
		host_rd_o    <= 1'b0;
		host_addr_o  <= ~host_addr_o;
		host_wdata_o <= ~host_wdata_o;
	endtask : idle
endmodule : afr_host_model
`default_nettype wire

// *** tb/afr_register_map_margin_high_tb.sv ***
// Self-checking bench for the register map with a host model on the request side.
// Assumes the checker is bound to the design separately.
`timescale 1ns/1ps
`default_nettype none
`include "afr_defs.svh"
module afr_register_map_margin_high_tb;
	import afr_pkg::*;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        code_8bit_i = 1'b0;
	logic        host_wr, host_rd, rvalid, miss, c8, u0, u1;
	afr_addr_t   host_addr;
	afr_word_t   host_wdata, rdata, w, w0, w1;
	afr_code_t   ch0, ch1;
	logic [16:0] exp_q[$];
	int          miscompares = 0;
	int          samples_checked = 0;
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	afr_host_model host (.clk_i(clk_i), .host_wr_o(host_wr), .host_rd_o(host_rd), .host_addr_o(host_addr),
		.host_wdata_o(host_wdata));
	afr_regmap uut (.clk_i(clk_i), .reset_i(reset_i), .host_wr_i(host_wr), .host_rd_i(host_rd),
		.host_addr_i(host_addr), .host_wdata_i(host_wdata), .host_rvalid_o(rvalid), .host_rdata_o(rdata),
		.host_miss_o(miss), .code_8bit_i(code_8bit_i), .code_8bit_o(c8), .ch0_margin_high_o(ch0),
		.ch1_margin_high_o(ch1), .ch0_margin_high_upd_o(u0), .ch1_margin_high_upd_o(u1));
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude
	task automatic rd_exp(input afr_addr_t a, input logic [16:0] e);
		host.rd(a);
		exp_q.push_back(e);
	endtask : rd_exp
	task automatic settle();
		host.idle();
		repeat (4) @(posedge clk_i);
	endtask : settle
	task automatic do_reset();
		@(posedge clk_i);
		reset_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
	endtask : do_reset
	always @(posedge clk_i) begin
		if (!reset_i && rvalid === 1'b1) begin
			if (exp_q.size() == 0) check(17'h1ffff, 17'h00000);
			else check({miss, rdata}, exp_q.pop_front());
		end
	end
	initial begin
		#20000;
		miscompares++;
		conclude();
	end
	initial begin
		w = afr_word_t'($urandom(32'h604b));
		do_reset();
		rd_exp(`AFR_A_NO_OP, 17'h00000);
		rd_exp(`AFR_A_CH0_MH, 17'h00000);
		rd_exp(`AFR_A_CH1_MH, 17'h00000);
		// Each write is followed at once by a read of the same address.
		for (int i = 0; i < 8; i++) begin
			w = afr_word_t'($urandom());
			if (i[0]) w1 = w;
			else w0 = w;
			host.wr(i[0] ? `AFR_A_CH1_MH : `AFR_A_CH0_MH, w);
			rd_exp(i[0] ? `AFR_A_CH1_MH : `AFR_A_CH0_MH, {1'b0, w[15:6], 6'h00});
		end
		settle();
		check({7'h00, ch0}, {7'h00, w0[15:6]});
		check({7'h00, ch1}, {7'h00, w1[15:6]});
		host.wr(`AFR_A_NO_OP, afr_word_t'($urandom()));
		rd_exp(`AFR_A_NO_OP, 17'h00000);
		rd_exp(7'h7f, 17'h10000);
		for (int i = 0; i < 3; i++) begin
			w = afr_word_t'($urandom());
			host.wr(i == 0 ? `AFR_A_SH_SETUP : i == 1 ? `AFR_A_PIN_SETUP : `AFR_A_SCR_WORD, w);
			rd_exp(i == 0 ? `AFR_A_SH_SETUP : i == 1 ? `AFR_A_PIN_SETUP : `AFR_A_SCR_WORD, {1'b0, w});
		end
		settle();
		check({7'h00, ch0}, {7'h00, w0[15:6]});
		code_8bit_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		check({16'h0000, c8}, 17'h00001);
		w = afr_word_t'($urandom());
		host.wr(`AFR_A_CH0_MH, w);
		rd_exp(`AFR_A_CH0_MH, {1'b0, w[15:8], 8'h00});
		settle();
		check({7'h00, ch0}, {7'h00, w[15:8], 2'b00});
		do_reset();
		check({7'h00, ch0}, 17'h00000);
		rd_exp(`AFR_A_CH1_MH, 17'h00000);
		settle();
		// Every expected answer must have been taken off the queue by now.
		check(17'(exp_q.size()), 17'h00000);
		conclude();
	end
endmodule : afr_register_map_margin_high_tb
`default_nettype wire

// *** tb/afr_regmap_sva.sv ***
// Checker for the register map host port: read latency, margin code capture and no-operation behaviour.
// Assumes it is bound to afr_regmap and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "afr_defs.svh"
module afr_regmap_sva (
	// Clock and reset
	input wire logic               clk_i,
	input wire logic               reset_i,
	// Host register port
	input wire logic               host_wr_i,
	input wire logic               host_rd_i,
	input wire afr_pkg::afr_addr_t host_addr_i,
	input wire afr_pkg::afr_word_t host_wdata_i,
	input wire logic               host_rvalid_o,
	input wire afr_pkg::afr_word_t host_rdata_o,
	input wire logic               host_miss_o,
	// Strap and channel levels
	input wire logic               code_8bit_o,
	input wire afr_pkg::afr_code_t ch0_margin_high_o,
	input wire afr_pkg::afr_code_t ch1_margin_high_o,
	input wire logic               ch0_margin_high_upd_o,
	input wire logic               ch1_margin_high_upd_o
);
	import afr_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// A read that coincides with a write is dropped, so only lone reads expect an answer.
	wire logic rd_only = host_rd_i && !host_wr_i;
	wire logic wr0     = host_wr_i && host_addr_i == `AFR_A_CH0_MH;
	wire logic wr1     = host_wr_i && host_addr_i == `AFR_A_CH1_MH;
	wire logic at_no_op = host_addr_i == `AFR_A_NO_OP;
	chk_read_answer_latency: assert property (rd_only |-> ##2 host_rvalid_o)
		else $error("read answer missing two cycles after request");
	chk_no_op_reads_zero: assert property (rd_only && at_no_op |-> ##2 host_rdata_o == `AFR_NO_OP_VAL)
		else $error("address zero read nonzero");
	chk_no_op_not_missed: assert property ((host_rd_i || host_wr_i) && at_no_op |-> ##2 !host_miss_o)
		else $error("address zero reported as unmapped");
	chk_ch0_code_capture: assert property (wr0 |=> ch0_margin_high_o ==
		{$past(host_wdata_i[15:8]), $past(host_wdata_i[7:6]) & {2{!$past(code_8bit_o)}}})
		else $error("channel 0 code not taken from write bits");
	chk_ch1_code_capture: assert property (wr1 |=> ch1_margin_high_o ==
		{$past(host_wdata_i[15:8]), $past(host_wdata_i[7:6]) & {2{!$past(code_8bit_o)}}})
		else $error("channel 1 code not taken from write bits");
	chk_ch0_upd_cause: assert property (ch0_margin_high_upd_o |-> $past(wr0) && !ch1_margin_high_upd_o)
		else $error("channel 0 update without its own write");
	chk_ch1_upd_pulse: assert property (wr1 |=> ch1_margin_high_upd_o ##1 (!ch1_margin_high_upd_o || $past(wr1)))
		else $error("channel 1 update pulse wrong");
	chk_codes_hold_still: assert property (!wr0 && !wr1 |=> $stable(ch0_margin_high_o) && $stable(ch1_margin_high_o))
		else $error("margin code changed without its write");
	chk_margin_low_bits: assert property (rd_only && host_addr_i == `AFR_A_CH0_MH |-> ##2 host_rdata_o[5:0] == 6'h00)
		else $error("margin read shows bits below the code");
endmodule : afr_regmap_sva
bind afr_regmap afr_regmap_sva chk (.clk_i(clk_i), .reset_i(reset_i), .host_wr_i(host_wr_i),
	.host_rd_i(host_rd_i), .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i),
	.host_rvalid_o(host_rvalid_o), .host_rdata_o(host_rdata_o), .host_miss_o(host_miss_o),
	.code_8bit_o(code_8bit_o), .ch0_margin_high_o(ch0_margin_high_o), .ch1_margin_high_o(ch1_margin_high_o),
	.ch0_margin_high_upd_o(ch0_margin_high_upd_o), .ch1_margin_high_upd_o(ch1_margin_high_upd_o));
`default_nettype wire

// *** verilog/afr_defs.svh ***
// Constants of the front-end register map: widths, addresses, field positions and reset values.
// Assumes it is included by bare name from every file that needs these figures.
`ifndef AFR_DEFS_SVH
`define AFR_DEFS_SVH

// Host port widths, word store slot width and slot count.
`define AFR_AW             7
`define AFR_DW             16
`define AFR_SW             5
`define AFR_SLOTS          32

// Published register addresses.
`define AFR_A_NO_OP        7'h00
`define AFR_A_CH2_MH       7'h01
`define AFR_A_CH2_ML       7'h02
`define AFR_A_CH2_GAIN     7'h03
`define AFR_A_CH2_FUNC     7'h06
`define AFR_A_CH0_MH       7'h0d
`define AFR_A_CH0_ML       7'h0e
`define AFR_A_CH0_GAIN     7'h0f
`define AFR_A_CH0_FUNC     7'h12
`define AFR_A_CH1_MH       7'h13
`define AFR_A_CH1_ML       7'h14
`define AFR_A_CH1_GAINCMP  7'h15
`define AFR_A_CH1_CMPMODE  7'h17
`define AFR_A_CH1_FUNC     7'h18
`define AFR_A_CH2_DATA     7'h19
`define AFR_A_CH0_DATA     7'h1b
`define AFR_A_CH1_DATA     7'h1c
`define AFR_A_CONV_SETUP   7'h1d
`define AFR_A_CONV_RESULT  7'h1e
`define AFR_A_SH_SETUP     7'h1f
`define AFR_A_SH_TRIG      7'h20
`define AFR_A_SH_OUT_TRIG  7'h21
`define AFR_A_STATUS       7'h22
`define AFR_A_COMPARATOR_STATUS   7'h23
`define AFR_A_PIN_SETUP    7'h24
`define AFR_A_DEV_SETUP    7'h25
`define AFR_A_PORT_SETUP   7'h26
`define AFR_A_SCR_PTR      7'h2b
`define AFR_A_SCR_WORD     7'h2c
`define AFR_A_ALL_CODE     7'h50

// Margin-high code field: 10-bit code at bits 15..6, 8-bit code at bits 15..8.
`define AFR_MH_MSB         15
`define AFR_MH_LSB         6
`define AFR_MH_W           10
`define AFR_MH8_PAD        2
`define AFR_MH_LOW_W       6

// Reset and fixed read values.
`define AFR_MH_RST         10'h000
`define AFR_NO_OP_VAL      16'h0000
`define AFR_WORD_RST       16'h0000
`define AFR_ZERO_WORD      16'h0000

`endif

// *** verilog/afr_mem_if.sv ***
// Carrier between the register map control and its word store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "afr_defs.svh"

interface afr_mem_if;
	logic                wr_en;
	logic                rd_en;
	logic [`AFR_SW-1:0]  slot;
	logic [`AFR_DW-1:0]  wdata;
	logic [`AFR_DW-1:0]  rdata;

	modport ctrl (output wr_en, output rd_en, output slot, output wdata, input rdata);
	modport store (input wr_en, input rd_en, input slot, input wdata, output rdata);
endinterface : afr_mem_if

`default_nettype wire

// *** verilog/afr_pkg.sv ***
// Types shared by the front-end register map design.
// Assumes afr_defs.svh supplies the widths.
`default_nettype none
`include "afr_defs.svh"

package afr_pkg;

	typedef logic [`AFR_AW-1:0] afr_addr_t;
	typedef logic [`AFR_DW-1:0] afr_word_t;
	typedef logic [`AFR_SW-1:0] afr_slot_t;
	typedef logic [`AFR_MH_W-1:0] afr_code_t;

	// Where a read answer is taken from.
	typedef enum logic [3:0] {
		AFR_SRC_ZERO = 4'b0001,
		AFR_SRC_CH0  = 4'b0010,
		AFR_SRC_CH1  = 4'b0100,
		AFR_SRC_MEM  = 4'b1000
	} afr_src_t;

	// Result of decoding one host address.
	typedef struct packed {
		logic      mapped;
		logic      writable;
		logic      in_mem;
		afr_slot_t slot;
	} afr_dec_t;

endpackage : afr_pkg

`default_nettype wire

// *** verilog/afr_regmap.sv ***
// Register map of a three-channel analogue front end as seen from its serial host port.
// Assumes the serial front end delivers decoded one-cycle read and write requests on clk_i,
// and that the resolution strap is a slow pin from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "afr_defs.svh"

// How it works
// R01 - Address zero reads sixteen zero bits, is read-only, and triggers nothing.
// R02 - Channel 0 margin-high code sits at 0Dh, read-write, resets to zero.
// R03 - Channel 1 margin-high code sits at 13h, read-write, resets to zero.
// R04 - Each margin-high register drives only its own channel's margin-high level.
// R05 - Codes are unsigned straight binary with the code MSB at bit 15.
// R06 - Ten-bit variant: code in bits 15..6; lower bits ignored on write.
// R07 - Eight-bit variant: code in bits 15..8; lower bits are don't-care.
// R08 - Writing address zero changes nothing; it still reads back zero.
module afr_regmap (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	// Host register port
	input  wire logic                  host_wr_i,
	input  wire logic                  host_rd_i,
	input  wire afr_pkg::afr_addr_t    host_addr_i,
	input  wire afr_pkg::afr_word_t    host_wdata_i,
	output logic                       host_rvalid_o,
	output afr_pkg::afr_word_t         host_rdata_o,
	output logic                       host_miss_o,
	// Resolution strap, high selects the eight-bit variant
	input  wire logic                  code_8bit_i,
	output logic                       code_8bit_o,
	// Channel margin-high levels
	output afr_pkg::afr_code_t         ch0_margin_high_o,
	output afr_pkg::afr_code_t         ch1_margin_high_o,
	output logic                       ch0_margin_high_upd_o,
	output logic                       ch1_margin_high_upd_o
);
	import afr_pkg::*;

	// Address decode shared by the read and write paths.
	function automatic afr_dec_t afr_decode(input afr_addr_t a);
		afr_dec_t d;
		d = '{mapped: 1'b1, writable: 1'b1, in_mem: 1'b1, slot: 5'h00};
		case (a)
			`AFR_A_NO_OP:       d = '{1'b1, 1'b0, 1'b0, 5'h00};
			`AFR_A_CH0_MH:      d = '{1'b1, 1'b1, 1'b0, 5'h00};
			`AFR_A_CH1_MH:      d = '{1'b1, 1'b1, 1'b0, 5'h00};
			`AFR_A_CH2_MH:      d.slot = 5'h00;
			`AFR_A_CH2_ML:      d.slot = 5'h01;
			`AFR_A_CH2_GAIN:    d.slot = 5'h02;
			`AFR_A_CH2_FUNC:    d.slot = 5'h03;
			`AFR_A_CH0_ML:      d.slot = 5'h04;
			`AFR_A_CH0_GAIN:    d.slot = 5'h05;
			`AFR_A_CH0_FUNC:    d.slot = 5'h06;
			`AFR_A_CH1_ML:      d.slot = 5'h07;
			`AFR_A_CH1_GAINCMP: d.slot = 5'h08;
			`AFR_A_CH1_CMPMODE: d.slot = 5'h09;
			`AFR_A_CH1_FUNC:    d.slot = 5'h0a;
			`AFR_A_CH2_DATA:    d.slot = 5'h0b;
			`AFR_A_CH0_DATA:    d.slot = 5'h0c;
			`AFR_A_CH1_DATA:    d.slot = 5'h0d;
			`AFR_A_CONV_SETUP:  d.slot = 5'h0e;
			`AFR_A_SH_SETUP:    d.slot = 5'h0f;
			`AFR_A_SH_TRIG:     d.slot = 5'h10;
			`AFR_A_SH_OUT_TRIG: d.slot = 5'h11;
			`AFR_A_PIN_SETUP:   d.slot = 5'h12;
			`AFR_A_DEV_SETUP:   d.slot = 5'h13;
			`AFR_A_PORT_SETUP:  d.slot = 5'h14;
			`AFR_A_SCR_PTR:     d.slot = 5'h15;
			`AFR_A_SCR_WORD:    d.slot = 5'h16;
			`AFR_A_ALL_CODE:    d.slot = 5'h17;
			// Read-only status words have no source inside this block and read as zero.
			`AFR_A_CONV_RESULT: d = '{1'b1, 1'b0, 1'b0, 5'h00};
			`AFR_A_STATUS:      d = '{1'b1, 1'b0, 1'b0, 5'h00};
			`AFR_A_COMPARATOR_STATUS:  d = '{1'b1, 1'b0, 1'b0, 5'h00};
			default:            d = '{1'b0, 1'b0, 1'b0, 5'h00};
		endcase
		return d;
	endfunction : afr_decode

	// Takes a host word apart into a margin-high code for the active variant.
	function automatic afr_code_t afr_pick_code(input afr_word_t w, input logic narrow);
		afr_code_t c;
		c = w[`AFR_MH_MSB:`AFR_MH_LSB];
		if (narrow) begin
			c[`AFR_MH8_PAD-1:0] = '0;
		end
		return c;
	endfunction : afr_pick_code

	// Strap synchroniser and its filtered level.
	logic      strap_s1_q;
	logic      strap_s2_q;
	logic      strap_s3_q;
	logic      narrow_q;

	// Register state.
	afr_code_t ch0_mh_q;
	afr_code_t ch1_mh_q;
	logic      ch0_upd_q;
	logic      ch1_upd_q;

	// Read pipeline.
	logic      rd_p1_q;
	logic      miss_p1_q;
	afr_src_t  src_p1_q;
	logic      rvalid_q;
	logic      miss_q;
	afr_word_t rdata_q;
	afr_word_t rdata_d;

	// Decode of the present request.
	afr_dec_t  dec;
	logic      wr_go;
	logic      rd_go;
	logic      wr_ch0;
	logic      wr_ch1;
	logic      wr_mem;
	afr_src_t  src_d;
	afr_code_t new_code;

	afr_mem_if mem_bus ();

	afr_word_store u_store (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.mem     (mem_bus.store)
	);

	assign dec      = afr_decode(host_addr_i);
	// A write and a read in the same cycle: the write is taken and the read is dropped.
	assign wr_go    = host_wr_i;
	assign rd_go    = host_rd_i & ~host_wr_i;
	assign new_code = afr_pick_code(host_wdata_i, narrow_q); // R05 R06 R07
	assign wr_ch0   = wr_go & (host_addr_i == `AFR_A_CH0_MH); // R02
	assign wr_ch1   = wr_go & (host_addr_i == `AFR_A_CH1_MH); // R03
	// Address zero and the read-only words are not writable, so nothing moves. R01 R08
	assign wr_mem   = wr_go & dec.mapped & dec.writable & dec.in_mem;

	assign src_d = (!dec.mapped || !(dec.writable || dec.in_mem)) ? AFR_SRC_ZERO :
		(host_addr_i == `AFR_A_CH0_MH) ? AFR_SRC_CH0 :
		(host_addr_i == `AFR_A_CH1_MH) ? AFR_SRC_CH1 : AFR_SRC_MEM;

	assign mem_bus.wr_en = wr_mem;
	assign mem_bus.rd_en = rd_go & dec.in_mem;
	assign mem_bus.slot  = dec.slot;
	assign mem_bus.wdata = host_wdata_i;

	// The strap is sampled through three stages; the level moves only when stages two and three agree.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
			strap_s3_q <= 1'b0;
		end else begin
			strap_s1_q <= code_8bit_i;
			strap_s2_q <= strap_s1_q;
			strap_s3_q <= strap_s2_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			narrow_q <= 1'b0;
		end else if (strap_s2_q == strap_s3_q) begin
			narrow_q <= strap_s3_q;
		end
	end

	// Margin-high code registers, one each for channels 0 and 1.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ch0_mh_q <= `AFR_MH_RST; // R02
		end else if (wr_ch0) begin
			ch0_mh_q <= new_code; // R02 R04
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ch1_mh_q <= `AFR_MH_RST; // R03
		end else if (wr_ch1) begin
			ch1_mh_q <= new_code; // R03 R04
		end
	end

	// One-cycle notice to the channel that its margin-high level was rewritten.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ch0_upd_q <= 1'b0;
			ch1_upd_q <= 1'b0;
		end else begin
			ch0_upd_q <= wr_ch0; // R04
			ch1_upd_q <= wr_ch1; // R04
		end
	end

	// First read stage: remember where the answer comes from while the store reads.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rd_p1_q   <= 1'b0;
			miss_p1_q <= 1'b0;
			src_p1_q  <= AFR_SRC_ZERO;
		end else begin
			rd_p1_q   <= rd_go;
			miss_p1_q <= (rd_go | wr_go) & ~dec.mapped;
			src_p1_q  <= src_d;
		end
	end

	// Reads of a margin-high word return the code left aligned with zeros below it. R05
	always_comb begin
		case (src_p1_q)
			AFR_SRC_ZERO: rdata_d = `AFR_NO_OP_VAL; // R01 R08
			AFR_SRC_CH0:  rdata_d = {ch0_mh_q, {`AFR_MH_LOW_W{1'b0}}}; // R06 R07
			AFR_SRC_CH1:  rdata_d = {ch1_mh_q, {`AFR_MH_LOW_W{1'b0}}}; // R06 R07
			AFR_SRC_MEM:  rdata_d = mem_bus.rdata;
			default:      rdata_d = `AFR_ZERO_WORD;
		endcase
	end

	// Second read stage: the answer and its valid leave from flip-flops.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rvalid_q <= 1'b0;
			miss_q   <= 1'b0;
			rdata_q  <= `AFR_ZERO_WORD;
		end else begin
			rvalid_q <= rd_p1_q;
			miss_q   <= miss_p1_q;
			if (rd_p1_q) begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign host_rvalid_o         = rvalid_q;
	assign host_rdata_o          = rdata_q;
	assign host_miss_o           = miss_q;
	assign code_8bit_o           = narrow_q;
	assign ch0_margin_high_o     = ch0_mh_q; // R04
	assign ch1_margin_high_o     = ch1_mh_q; // R04
	assign ch0_margin_high_upd_o = ch0_upd_q;
	assign ch1_margin_high_upd_o = ch1_upd_q;

endmodule : afr_regmap

`default_nettype wire

// *** verilog/afr_word_store.sv ***
// Small word memory holding the read-write registers that have no logic behind them here.
// Assumes the control side presents a valid slot; read data appear one edge after rd_en.
`timescale 1ns/1ps
`default_nettype none
`include "afr_defs.svh"

module afr_word_store (
	// Clock and reset
	input  wire logic  clk_i,
	input  wire logic  reset_i,
	// Access port
	afr_mem_if.store   mem
);
	import afr_pkg::*;

	afr_word_t words_q [0:`AFR_SLOTS-1];
	afr_word_t rdata_q;

	assign mem.rdata = rdata_q;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < `AFR_SLOTS; i++) begin
				words_q[i] <= `AFR_WORD_RST;
			end
		end else if (mem.wr_en) begin
			words_q[mem.slot] <= mem.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_q <= `AFR_WORD_RST;
		end else if (mem.rd_en) begin
			rdata_q <= words_q[mem.slot];
		end
	end

endmodule : afr_word_store

`default_nettype wire
